// [rtl/tws_pkg.sv]
// Shared constants and types for the two-wire EEPROM slave front end and its master
package tws_pkg;

  // Bus timing, host side
  localparam int SCL_PERIOD_NS = 2500;
  localparam int CORE_PERIOD_NS = 20;
  localparam int QTR_NS = SCL_PERIOD_NS / 4;
  // Least time, so round up to whole core cycles
  localparam int QTR_CYC = (QTR_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int DIV_W = 16;

  // Byte framing
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] FIRST_CNT = 4'h1;
  localparam logic [3:0] RECOVER_MAX = 4'h9;

  // Device address byte layout
  localparam int DA_TYPE_HI = 7;
  localparam int DA_TYPE_LO = 4;
  localparam int DA_PIN_HI = 3;
  localparam int DA_PIN_LO = 2;
  localparam int DA_TOP = 1;
  localparam int DA_RW = 0;

  // Array organisation
  localparam int PAGES = 32;
  localparam int PAGE_BYTES = 16;
  localparam int ARRAY_AW = $clog2(PAGES * PAGE_BYTES);

  // Device end states
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01,
    DS_DEV = 5'h02,
    DS_WORD = 5'h04,
    DS_DATA = 5'h08,
    DS_SEND = 5'h10
  } tws_dev_state_type;

  // Master end states
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_START = 5'h02,
    HS_BYTE = 5'h04,
    HS_STOP = 5'h08,
    HS_RECOVER = 5'h10
  } tws_host_state_type;

  // Master commands
  typedef enum logic [2:0] {
    CMD_START = 3'h0,
    CMD_STOP = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_READ = 3'h3,
    CMD_RECOVER = 3'h4
  } tws_cmd_type;

  localparam logic [1:0] PH_0 = 2'h0;
  localparam logic [1:0] PH_1 = 2'h1;
  localparam logic [1:0] PH_2 = 2'h2;
  localparam logic [1:0] PH_3 = 2'h3;

endpackage : tws_pkg

// [rtl/tws_link_if.sv]
// Two-wire link between the master end and the EEPROM slave end
`timescale 1ns/1ns
interface tws_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic sda;

  // Open-drain wire with pull-up: any enabled low driver wins
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface : tws_link_if

// [rtl/tws_slave.sv]
// EEPROM two-wire slave front end, clocked by the link clock
`timescale 1ns/1ns
module tws_slave #(
  parameter logic [3:0] DEV_TYPE_ID = 4'h5 // Arbitrary value
) (
  tws_link_if.slave link,
  input wire logic rst_i,
  input wire logic hw_addr_pin_hi_i,
  input wire logic hw_addr_pin_lo_i,
  input wire logic write_busy_i,
  input wire logic [7:0] rd_data_i,
  output logic selected_o,
  output logic read_o,
  output logic addr_valid_o,
  output logic [tws_pkg::ARRAY_AW-1:0] word_addr_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic rd_taken_o,
  output logic standby_o
);
  import tws_pkg::*;

  function automatic logic addr_match(input logic [7:0] b, input logic busy);
    addr_match = (b[DA_TYPE_HI:DA_TYPE_LO] == DEV_TYPE_ID)
      && (b[DA_PIN_HI] == hw_addr_pin_hi_i) && (b[DA_PIN_LO] == hw_addr_pin_lo_i)
      && !busy;
  endfunction : addr_match

  // Start and stop detectors, clocked by SDA edges themselves
  logic start_tog_q, start_tog_d;
  logic sess_q, sess_d;
  logic stop_tog_q, stop_tog_d;

  // Link state, sampled on SCL rise
  tws_dev_state_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, sh_in;
  logic [7:0] tx_q, tx_d;
  logic ack_q, ack_d;
  logic rw_q, rw_d;
  logic top_q, top_d;
  logic sel_q, sel_d;
  logic start_ack_q, start_ack_d;
  logic stop_ack_q, stop_ack_d;
  logic [ARRAY_AW-1:0] wa_q, wa_d;
  logic [7:0] rxb_q, rxb_d;
  logic av_q, av_d;
  logic rv_q, rv_d;
  logic rt_q, rt_d;
  logic start_pend, stop_pend;

  // Drive state, updated on SCL fall
  logic oe_q, oe_d;

  assign start_pend = start_tog_q ^ start_ack_q;
  assign stop_pend = stop_tog_q ^ stop_ack_q;

  always_comb begin
    start_tog_d = link.scl ? ~start_tog_q : start_tog_q;
    sess_d = link.scl ? ~stop_tog_q : sess_q;
    stop_tog_d = link.scl ? ~stop_tog_q : stop_tog_q;
  end

  // Stop toggle only moves on an SDA rise while SCL is high, so it is stable on this SDA fall
  always_ff @(negedge link.sda or posedge rst_i) begin
    if (rst_i) begin
      start_tog_q <= 1'b0;
      sess_q <= 1'b0;
    end else begin
      start_tog_q <= start_tog_d;
      sess_q <= sess_d;
    end
  end

  always_ff @(posedge link.sda or posedge rst_i) begin
    if (rst_i) begin
      stop_tog_q <= 1'b0;
    end else begin
      stop_tog_q <= stop_tog_d;
    end
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_in = {sh_q[6:0], link.sda};
    sh_d = sh_q;
    tx_d = tx_q;
    ack_d = ack_q;
    rw_d = rw_q;
    top_d = top_q;
    sel_d = sel_q;
    start_ack_d = start_ack_q;
    stop_ack_d = stop_ack_q;
    wa_d = wa_q;
    rxb_d = rxb_q;
    av_d = 1'b0;
    rv_d = 1'b0;
    rt_d = 1'b0;
    if (start_pend) begin
      // Any byte in flight is dropped; this edge carries bit 7 of a new address
      st_d = DS_DEV;
      sh_d = sh_in;
      cnt_d = FIRST_CNT;
      ack_d = 1'b0;
      sel_d = 1'b0;
      start_ack_d = start_tog_q;
      stop_ack_d = stop_tog_q;
    end else if (stop_pend) begin
      st_d = DS_IDLE;
      cnt_d = '0;
      sel_d = 1'b0;
      stop_ack_d = stop_tog_q;
    end else if (st_q != DS_IDLE) begin
      if (cnt_q != ACK_SLOT) begin
        sh_d = sh_in;
        cnt_d = cnt_q + FIRST_CNT;
        if (cnt_q == LAST_BIT) begin
          unique case (st_q)
            DS_DEV: begin
              ack_d = addr_match(sh_in, write_busy_i);
              top_d = sh_in[DA_TOP];
              rw_d = sh_in[DA_RW];
            end
            DS_WORD: begin
              ack_d = 1'b1;
              wa_d = {top_q, sh_in};
              av_d = 1'b1;
            end
            DS_DATA: begin
              ack_d = 1'b1;
              rxb_d = sh_in;
              rv_d = 1'b1;
            end
            default: begin
              ack_d = 1'b0;
            end
          endcase
        end
      end else begin
        cnt_d = '0;
        unique case (st_q)
          DS_DEV: begin
            if (!ack_q) begin
              st_d = DS_IDLE;
            end else if (rw_q) begin
              st_d = DS_SEND;
              sel_d = 1'b1;
              tx_d = rd_data_i;
              rt_d = 1'b1;
            end else begin
              st_d = DS_WORD;
              sel_d = 1'b1;
            end
          end
          DS_SEND: begin
            if (!link.sda) begin
              tx_d = rd_data_i;
              rt_d = 1'b1;
            end else begin
              st_d = DS_IDLE;
              sel_d = 1'b0;
            end
          end
          default: begin
            st_d = DS_DATA;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link.scl or posedge rst_i) begin
    if (rst_i) begin
      st_q <= DS_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      tx_q <= '0;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      top_q <= 1'b0;
      sel_q <= 1'b0;
      start_ack_q <= 1'b0;
      stop_ack_q <= 1'b0;
      wa_q <= '0;
      rxb_q <= '0;
      av_q <= 1'b0;
      rv_q <= 1'b0;
      rt_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ack_q <= ack_d;
      rw_q <= rw_d;
      top_q <= top_d;
      sel_q <= sel_d;
      start_ack_q <= start_ack_d;
      stop_ack_q <= stop_ack_d;
      wa_q <= wa_d;
      rxb_q <= rxb_d;
      av_q <= av_d;
      rv_q <= rv_d;
      rt_q <= rt_d;
    end
  end

  // Nothing is driven between a start and its first rising clock
  always_comb begin
    oe_d = 1'b0;
    if (!start_pend) begin
      if (st_q != DS_IDLE && st_q != DS_SEND && cnt_q == ACK_SLOT && ack_q) begin
        oe_d = 1'b1;
      end else if (st_q == DS_SEND && cnt_q != ACK_SLOT) begin
        oe_d = ~tx_q[3'(LAST_BIT - cnt_q)];
      end
    end
  end

  always_ff @(negedge link.scl or posedge rst_i) begin
    if (rst_i) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe = oe_q;
  assign selected_o = sel_q;
  assign read_o = rw_q;
  assign addr_valid_o = av_q;
  assign word_addr_o = wa_q;
  assign rx_valid_o = rv_q;
  assign rx_byte_o = rxb_q;
  assign rd_taken_o = rt_q;
  // Bus counts as idle once the stop toggle catches the session flag
  assign standby_o = (sess_q == stop_tog_q) && !write_busy_i;

endmodule : tws_slave

// [rtl/tws_master.sv]
// Two-wire bus master end: divides the core clock down to SCL and frames bytes
`timescale 1ns/1ns
module tws_master #(
  parameter int QTR_CYC = tws_pkg::QTR_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  tws_link_if.master link,
  input wire logic cmd_valid_i,
  input wire tws_pkg::tws_cmd_type cmd_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_ack_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic [7:0] rd_data_o,
  output logic nack_o
);
  import tws_pkg::*;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QTR_CYC - 1);

  tws_host_state_type st_q;
  tws_host_state_type st_d;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [8:0] sh_q;
  logic [8:0] sh_d;
  logic [8:0] rx_q;
  logic [8:0] rx_d;
  logic scl_q;
  logic scl_d;
  logic oe_q;
  logic oe_d;
  logic rdy_q;
  logic rdy_d;
  logic done_q;
  logic done_d;
  logic [7:0] rdd_q;
  logic [7:0] rdd_d;
  logic nack_q;
  logic nack_d;
  logic sda_s1_q;
  logic sda_s2_q;
  logic tick;

  assign tick = (div_q == DIV_LAST);

  always_comb begin
    st_d = st_q;
    div_d = tick ? '0 : div_q + DIV_W'(1);
    ph_d = tick ? ph_q + PH_1 : ph_q;
    bit_d = bit_q;
    sh_d = sh_q;
    rx_d = rx_q;
    scl_d = scl_q;
    oe_d = oe_q;
    rdy_d = 1'b0;
    done_d = 1'b0;
    rdd_d = rdd_q;
    nack_d = nack_q;
    unique case (st_q)
      HS_IDLE: begin
        rdy_d = 1'b1;
        div_d = '0;
        ph_d = PH_0;
        bit_d = '0;
        if (cmd_valid_i && rdy_q) begin
          rdy_d = 1'b0;
          unique case (cmd_i)
            CMD_START: st_d = HS_START;
            CMD_STOP: st_d = HS_STOP;
            CMD_WRITE: begin
              st_d = HS_BYTE;
              sh_d = {cmd_data_i, 1'b1};
            end
            CMD_READ: begin
              st_d = HS_BYTE;
              sh_d = {8'hFF, ~cmd_ack_i};
            end
            CMD_RECOVER: st_d = HS_RECOVER;
            default: st_d = HS_IDLE;
          endcase
        end
      end
      HS_START: begin
        if (tick) begin
          unique case (ph_q)
            PH_0: oe_d = 1'b0;
            PH_1: scl_d = 1'b1;
            PH_2: oe_d = 1'b1;
            PH_3: begin
              scl_d = 1'b0;
              st_d = HS_IDLE;
              done_d = 1'b1;
            end
          endcase
        end
      end
      HS_BYTE: begin
        if (tick) begin
          if (bit_q == RECOVER_MAX) begin
            oe_d = 1'b0;
            st_d = HS_IDLE;
            done_d = 1'b1;
            rdd_d = rx_q[8:1];
            nack_d = rx_q[0];
          end else begin
            unique case (ph_q)
              PH_0: oe_d = ~sh_q[8];
              PH_1: scl_d = 1'b1;
              PH_2: rx_d = {rx_q[7:0], sda_s2_q};
              PH_3: begin
                scl_d = 1'b0;
                sh_d = {sh_q[7:0], 1'b1};
                bit_d = bit_q + FIRST_CNT;
              end
            endcase
          end
        end
      end
      HS_STOP: begin
        if (tick) begin
          unique case (ph_q)
            PH_0: scl_d = 1'b0;
            PH_1: oe_d = 1'b1;
            PH_2: scl_d = 1'b1;
            PH_3: begin
              oe_d = 1'b0;
              st_d = HS_IDLE;
              done_d = 1'b1;
            end
          endcase
        end
      end
      HS_RECOVER: begin
        if (tick) begin
          unique case (ph_q)
            PH_0: oe_d = 1'b0;
            PH_1: scl_d = 1'b1;
            PH_2: begin
              if (sda_s2_q) begin
                // Both lines high already: re-enter at the start's SDA fall, not past it
                st_d = HS_START;
                ph_d = PH_2;
              end
            end
            PH_3: begin
              scl_d = 1'b0;
              bit_d = bit_q + FIRST_CNT;
              if (bit_q == RECOVER_MAX - FIRST_CNT) begin
                st_d = HS_START;
              end
            end
          endcase
        end
      end
      default: st_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= HS_IDLE;
      div_q <= '0;
      ph_q <= PH_0;
      bit_q <= '0;
      sh_q <= '1;
      rx_q <= '0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      rdy_q <= 1'b0;
      done_q <= 1'b0;
      rdd_q <= '0;
      nack_q <= 1'b0;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      rx_q <= rx_d;
      scl_q <= scl_d;
      oe_q <= oe_d;
      rdy_q <= rdy_d;
      done_q <= done_d;
      rdd_q <= rdd_d;
      nack_q <= nack_d;
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  assign link.scl = scl_q;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe = oe_q;
  assign cmd_ready_o = rdy_q;
  assign done_o = done_q;
  assign rd_data_o = rdd_q;
  assign nack_o = nack_q;

endmodule : tws_master

// [rtl/placeholder_none.sv]
// Intentionally empty compilation unit
`timescale 1ns/1ns

// [verif/tws_link_monitor.sv]
// Link protocol checker for the slave end, sampled on the core clock
`timescale 1ns/1ns
module tws_link_monitor #(
  parameter logic [3:0] DEV_TYPE_ID = 4'h5
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic hw_addr_pin_hi_i,
  input wire logic hw_addr_pin_lo_i,
  input wire logic write_busy_i
);
  logic scl_q, sda_q, rise, start, stop, match;
  logic first_q, first_d, rd_q, rd_d, in_q, in_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;

  default clocking mon_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // Core clock oversamples the link, so edges show as level pairs
  assign rise = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  assign stop = scl & scl_q & ~sda_q & sda;
  assign match = (sh_q[7:4] == DEV_TYPE_ID) && (sh_q[3] == hw_addr_pin_hi_i)
    && (sh_q[2] == hw_addr_pin_lo_i) && !write_busy_i;

  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    first_d = first_q;
    rd_d = rd_q;
    in_d = in_q;
    if (start) begin
      cnt_d = 4'h0;
      first_d = 1'b1;
      rd_d = 1'b0;
      in_d = 1'b1;
    end else if (stop) begin
      in_d = 1'b0;
    end else if (rise) begin
      cnt_d = (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
      if (cnt_q != 4'h8) sh_d = {sh_q[6:0], sda};
      if (cnt_q == 4'h8) begin
        first_d = 1'b0;
        // Read only counts once the slave took the address
        if (first_q) rd_d = sh_q[0] & s_sda_oe;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      in_q <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      first_q <= first_d;
      rd_q <= rd_d;
      in_q <= in_d;
    end
  end

  oe_low_only_a: assert property (s_sda_oe |-> !s_sda_o)
    else $error("slave drives sda high");
  slave_edge_a: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave sda changed with scl high");
  ack_hold_a: assert property (rise && s_sda_oe |-> s_sda_oe [*6])
    else $error("slave low not held over scl high");
  idle_quiet_a: assert property (!in_q |-> !s_sda_oe)
    else $error("slave drives outside a transfer");
  addr_ack_a: assert property (rise && first_q && cnt_q == 4'h8 |-> s_sda_oe == match)
    else $error("address ack does not follow compare");
  ack_release_a: assert property (rise && cnt_q == 4'h8 && s_sda_oe && !rd_q
    && !(first_q && sh_q[0]) |-> ##[1:12] !s_sda_oe)
    else $error("ack not released after ninth clock");
  tx_release_a: assert property (rise && rd_q && cnt_q == 4'h8 |-> !s_sda_oe)
    else $error("transmitter holds sda in ack slot");
  nack_release_a: assert property (rise && rd_q && cnt_q == 4'h8 && sda |-> ##1 !s_sda_oe [*8])
    else $error("slave drives after master nack");
  ack_slot_a: assert property ($rose(s_sda_oe) && !rd_q |-> cnt_q == 4'h8)
    else $error("receiver ack outside ninth clock");

  cover property (start);
  cover property (rise && first_q && cnt_q == 4'h8 && s_sda_oe);
  cover property (rise && rd_q && cnt_q == 4'h8 && sda);
endmodule : tws_link_monitor

// [verif/eeprom_two_wire_slave_front_end_tb.sv]
// Bench joining master and slave ends over the link, driven by master commands
`timescale 1ns/1ns
module eeprom_two_wire_slave_front_end_tb;
  import tws_pkg::*;
  localparam logic [3:0] DEV_ID = 4'h6; // Arbitrary value
  localparam int QTR = 4; // Short quarters keep the run brief
  localparam logic [7:0] ADDR_W = {DEV_ID, 4'hA};
  localparam logic [7:0] ADDR_R = {DEV_ID, 4'h9};
  localparam logic [7:0] FLIP [3] = '{8'h04, 8'h08, 8'h80};
  logic core_clk_i = 1'b0;
  // Raised after time zero so the SDA-edge flops see a reset edge
  logic rst_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  tws_cmd_type cmd_i = CMD_START;
  logic [7:0] cmd_data_i = 8'h00;
  logic cmd_ack_i = 1'b0;
  logic hw_addr_pin_hi_i = 1'b1;
  logic hw_addr_pin_lo_i = 1'b0;
  logic write_busy_i = 1'b0;
  logic [7:0] rd_data_i = 8'h96;
  logic cmd_ready_o, done_o, nack_o, selected_o, read_o, addr_valid_o;
  logic rx_valid_o, rd_taken_o, standby_o;
  logic [7:0] rd_data_o, rx_byte_o;
  logic [ARRAY_AW-1:0] word_addr_o;
  int num_errors = 0;
  int checked = 0;
  int av_n = 0;
  int rv_n = 0;
  int rt_n = 0;

  tws_link_if u_tws_link_if();
  tws_master #(.QTR_CYC(QTR)) u_tws_master (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .link(u_tws_link_if),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_data_i(cmd_data_i),
    .cmd_ack_i(cmd_ack_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
    .rd_data_o(rd_data_o), .nack_o(nack_o));
  tws_slave #(.DEV_TYPE_ID(DEV_ID)) u_tws_slave (
    .link(u_tws_link_if), .rst_i(rst_i), .hw_addr_pin_hi_i(hw_addr_pin_hi_i),
    .hw_addr_pin_lo_i(hw_addr_pin_lo_i), .write_busy_i(write_busy_i),
    .rd_data_i(rd_data_i), .selected_o(selected_o), .read_o(read_o),
    .addr_valid_o(addr_valid_o), .word_addr_o(word_addr_o), .rx_valid_o(rx_valid_o),
    .rx_byte_o(rx_byte_o), .rd_taken_o(rd_taken_o), .standby_o(standby_o));
  tws_link_monitor #(.DEV_TYPE_ID(DEV_ID)) u_tws_link_monitor (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .scl(u_tws_link_if.scl),
    .sda(u_tws_link_if.sda), .s_sda_o(u_tws_link_if.s_sda_o),
    .s_sda_oe(u_tws_link_if.s_sda_oe), .hw_addr_pin_hi_i(hw_addr_pin_hi_i),
    .hw_addr_pin_lo_i(hw_addr_pin_lo_i), .write_busy_i(write_busy_i));

  always #10 core_clk_i = ~core_clk_i;

  // Strobes last one SCL period, so count them as they pass
  always @(posedge addr_valid_o) av_n++;
  always @(posedge rx_valid_o) rv_n++;
  always @(posedge rd_taken_o) rt_n++;

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  // Valid is offered only with ready high, since the master drops it otherwise
  task automatic send(input tws_cmd_type c, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    @(negedge core_clk_i);
    while (cmd_ready_o !== 1'b1 && n < 50) begin
      @(negedge core_clk_i);
      n++;
    end
    cmd_valid_i = 1'b1;
    cmd_i = c;
    cmd_data_i = d;
    cmd_ack_i = a;
    @(negedge core_clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 600) begin
      @(negedge core_clk_i);
      n++;
    end
    chk(done_o, 1'b1);
  endtask : send

  task automatic wr(input logic [7:0] d, input logic exp_nack);
    send(CMD_WRITE, d, 1'b0);
    chk(nack_o, exp_nack);
  endtask : wr

  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    #1;
    rst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk(standby_o, 1'b1);
    chk({u_tws_link_if.scl, u_tws_link_if.sda}, 2'b11);
    send(CMD_START, 8'h00, 1'b0);
    chk(standby_o, 1'b0);
    wr(ADDR_W, 1'b0);
    chk(selected_o, 1'b1);
    wr(8'hA5, 1'b0);
    chk(word_addr_o, 9'h1A5);
    wr(8'h3C, 1'b0);
    chk(rx_byte_o, 8'h3C);
    send(CMD_STOP, 8'h00, 1'b0);
    chk(standby_o, 1'b1);
    for (int i = 0; i < 3; i++) begin
      send(CMD_START, 8'h00, 1'b0);
      wr(ADDR_W ^ FLIP[i], 1'b1);
      send(CMD_STOP, 8'h00, 1'b0);
    end
    write_busy_i = 1'b1;
    @(negedge core_clk_i);
    chk(standby_o, 1'b0);
    send(CMD_START, 8'h00, 1'b0);
    wr(ADDR_W, 1'b1);
    send(CMD_STOP, 8'h00, 1'b0);
    write_busy_i = 1'b0;
    @(negedge core_clk_i);
    chk(standby_o, 1'b1);
    hw_addr_pin_hi_i = 1'b0;
    hw_addr_pin_lo_i = 1'b1;
    send(CMD_START, 8'h00, 1'b0);
    wr(ADDR_W ^ 8'h0E, 1'b0);
    wr(8'h07, 1'b0);
    chk(word_addr_o, 9'h007);
    send(CMD_START, 8'h00, 1'b0);
    wr(ADDR_R ^ 8'h0C, 1'b0);
    chk(read_o, 1'b1);
    send(CMD_READ, 8'h00, 1'b1);
    chk(rd_data_o, 8'h96);
    chk(nack_o, 1'b0);
    send(CMD_READ, 8'h00, 1'b0);
    chk(rd_data_o, 8'h96);
    chk({nack_o, u_tws_link_if.sda}, 2'b11);
    send(CMD_STOP, 8'h00, 1'b0);
    // All-zero byte keeps sda low so recovery needs every dummy clock
    hw_addr_pin_hi_i = 1'b1;
    hw_addr_pin_lo_i = 1'b0;
    rd_data_i = 8'h00;
    send(CMD_START, 8'h00, 1'b0);
    wr(ADDR_R, 1'b0);
    send(CMD_RECOVER, 8'h00, 1'b0);
    wr(ADDR_W, 1'b0);
    chk(selected_o, 1'b1);
    send(CMD_STOP, 8'h00, 1'b0);
    chk(9'(av_n), 9'h002);
    chk(9'(rv_n), 9'h001);
    chk(9'(rt_n), 9'h003);
    report_and_stop();
  end
endmodule : eeprom_two_wire_slave_front_end_tb
